// ==== src/ale_consts.svh ====
`ifndef ALE_CONSTS_SVH
`define ALE_CONSTS_SVH

// Decoded operation codes presented on op_i
`define ALE_OP_NOP      3'h0
`define ALE_OP_DEC_SKIP 3'h1
`define ALE_OP_INC_SKIP 3'h2
`define ALE_OP_INC_FILE 3'h3
`define ALE_OP_OR_LIT   3'h4
`define ALE_OP_OR_FILE  3'h5
`define ALE_OP_JUMP     3'h6

// Destination select values
`define ALE_DEST_ACC  1'h0
`define ALE_DEST_FILE 1'h1

// Field positions
`define ALE_JUMP_LO_MSB  10
`define ALE_LATCH_LO_BIT 3
`define ALE_LATCH_HI_BIT 4

// Reset values
`define ALE_ACC_RST  8'h00
`define ALE_PC_RST   13'h0000
`define ALE_ZERO_RST 1'h0

// Instruction cycle counts
`define ALE_CYC_PLAIN 2'h1
`define ALE_CYC_TWO   2'h2

`endif

// ==== src/ale_pkg.sv ====
package ale_pkg;

  // Execution sequencer states
  typedef enum logic {
    ALE_ST_EXEC,
    ALE_ST_DISCARD
  } ale_state_t;

  typedef logic [7:0] ale_byte_t;
  typedef logic [12:0] ale_pc_t;

endpackage

// ==== src/ale_alu_if.sv ====
`timescale 1ns/1ps

// Operands and result between sequencer and datapath
interface ale_alu_if;
  logic [2:0] op;
  ale_pkg::ale_byte_t acc;
  ale_pkg::ale_byte_t fdata;
  ale_pkg::ale_byte_t literal;
  ale_pkg::ale_byte_t result;
  logic result_zero;
  logic writes_zero;
  logic skips;

  modport seq (output op, output acc, output fdata, output literal,
               input result, input result_zero, input writes_zero, input skips);
  modport alu (input op, input acc, input fdata, input literal,
               output result, output result_zero, output writes_zero, output skips);
endinterface

// ==== src/ale_alu.sv ====
`timescale 1ns/1ps
`include "ale_consts.svh"

module ale_alu (
  // Operand and result bundle
  ale_alu_if.alu a
);

  // Result of the selected operation, wrapping modulo 256
  always_comb begin
    a.result = a.acc;
    a.writes_zero = 1'b0;
    a.skips = 1'b0;
    case (a.op)
      `ALE_OP_DEC_SKIP: begin
        a.result = a.fdata - 8'h01;
        a.skips = 1'b1;
      end
      `ALE_OP_INC_SKIP: begin
        a.result = a.fdata + 8'h01;
        a.skips = 1'b1;
      end
      `ALE_OP_INC_FILE: begin
        a.result = a.fdata + 8'h01;
        a.writes_zero = 1'b1;
      end
      `ALE_OP_OR_LIT: begin
        a.result = a.acc | a.literal;
        a.writes_zero = 1'b1;
      end
      `ALE_OP_OR_FILE: begin
        a.result = a.acc | a.fdata;
        a.writes_zero = 1'b1;
      end
      default: begin
        a.result = a.acc;
      end
    endcase
  end

  // All-zero detection of the 8-bit result
  assign a.result_zero = (a.result == 8'h00);

endmodule

// ==== src/ale_exec.sv ====
// Behaviour
// - Decrement-skip-on-null writes file minus one to the accumulator (d=0) or file (d=1), flags kept.
// - A zero decrement-skip-on-null result discards the next instruction as a NOP, two cycles total.
// - A nonzero skip-on-null result lets the next instruction execute with no cycle lost.
// - Increments add one and route by d; only plain increment updates the zero flag.
// - A zero increment-skip-on-null result substitutes a NOP for the next instruction, flags kept.
// - The absolute jump loads its 11-bit operand into program counter bits 10..0.
// - The absolute jump fills program counter bits 12..11 from upper jump latch bits 4..3.
// - The absolute jump is unconditional, takes two cycles and leaves flags unchanged.
// - OR-literal ORs an 8-bit literal into the accumulator and updates the zero flag.
// - OR-file ORs accumulator and file, routes by d and updates the zero flag.
`timescale 1ns/1ps
`include "ale_consts.svh"

module ale_exec (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Instruction slot, one per instruction cycle
  input wire logic instr_valid_i,
  input wire logic [2:0] op_i,
  input wire logic [6:0] file_addr_i,
  input wire logic dest_i,
  input wire logic [10:0] literal_i,
  // File register read data and jump latch
  input wire logic [7:0] file_rdata_i,
  input wire logic [7:0] upper_jump_latch_i,
  // File register write port
  output logic file_we_o,
  output logic [6:0] file_waddr_o,
  output logic [7:0] file_wdata_o,
  // Core state
  output logic [7:0] accumulator_o,
  output logic zero_flag_o,
  output logic [12:0] program_counter_o,
  // Per-cycle status
  output logic retire_o,
  output logic discard_o,
  output logic jump_o,
  output logic skip_taken_o,
  output logic [1:0] cycles_o,
  output logic illegal_op_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Sequential next address, wrapping over 13 bits
  function automatic ale_pkg::ale_pc_t pc_step(input ale_pkg::ale_pc_t pc);
    pc_step = pc + 13'h0001;
  endfunction

  // Jump target built from the operand and the latch
  // Only latch bits 4..3 reach the counter, the rest of the latch is ignored
  function automatic ale_pkg::ale_pc_t jump_target(input logic [10:0] k,
                                                   input logic [7:0] latch);
    jump_target = {latch[`ALE_LATCH_HI_BIT:`ALE_LATCH_LO_BIT],
                   k[`ALE_JUMP_LO_MSB:0]};
  endfunction

  // Operations that read the file register
  function automatic logic uses_file(input logic [2:0] op);
    uses_file = (op == `ALE_OP_DEC_SKIP) || (op == `ALE_OP_INC_SKIP) ||
                (op == `ALE_OP_INC_FILE) || (op == `ALE_OP_OR_FILE);
  endfunction

  // Codes inside the supported group
  function automatic logic is_known(input logic [2:0] op);
    is_known = (op <= `ALE_OP_JUMP);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Internal state and datapath

  ale_pkg::ale_state_t state;
  ale_pkg::ale_state_t next_state;
  ale_pkg::ale_byte_t acc;
  logic zero;
  ale_pkg::ale_pc_t pc;

  ale_alu_if alu_bus ();

  // Operands to the datapath
  assign alu_bus.op = op_i;
  assign alu_bus.acc = acc;
  assign alu_bus.fdata = file_rdata_i;
  assign alu_bus.literal = literal_i[7:0];

  ale_alu u_alu (
    .a(alu_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the current slot

  logic exec_now;
  logic is_jump;
  logic to_file;
  logic skip_now;
  logic next_discard;
  logic discarding;

  // The slot of this cycle falls in a discard cycle
  assign discarding = (state == ale_pkg::ALE_ST_DISCARD);
  // An instruction executes only outside a discard cycle
  assign exec_now = instr_valid_i && !discarding;
  assign is_jump = (op_i == `ALE_OP_JUMP);
  assign to_file = uses_file(op_i) && (dest_i == `ALE_DEST_FILE);
  // Skip only on a zero result; nonzero carries on normally
  assign skip_now = exec_now && alu_bus.skips && alu_bus.result_zero;
  // Jump always discards the prefetched slot
  assign next_discard = skip_now || (exec_now && is_jump);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  // Next state choice
  always_comb begin
    next_state = state;
    case (state)
      ale_pkg::ALE_ST_EXEC: begin
        if (next_discard) begin
          next_state = ale_pkg::ALE_ST_DISCARD;
        end
      end
      ale_pkg::ALE_ST_DISCARD: begin
        // The slot in this cycle is executed as a NOP
        // An idle cycle keeps waiting, so the next valid slot is the one dropped
        if (instr_valid_i) begin
          next_state = ale_pkg::ALE_ST_EXEC;
        end
      end
      default: begin
        next_state = ale_pkg::ALE_ST_EXEC;
      end
    endcase
  end

  // State register
  // Reset leaves the sequencer ready for a slot on the first edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ale_pkg::ALE_ST_EXEC;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator

  // Written by results routed to it, never in a discard cycle
  // Or-literal ignores the destination bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc <= `ALE_ACC_RST;
    end else if (exec_now) begin
      if (op_i == `ALE_OP_OR_LIT) begin
        acc <= alu_bus.result;
      end else if (uses_file(op_i) && (dest_i == `ALE_DEST_ACC)) begin
        acc <= alu_bus.result;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Zero flag

  // Updated only by operations that affect it
  // Skips, the jump and discarded slots leave it alone
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      zero <= `ALE_ZERO_RST;
    end else if (exec_now && alu_bus.writes_zero) begin
      zero <= alu_bus.result_zero;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter

  // Jump loads the target, every other valid slot steps, idle cycles hold
  // Discarded slots step too, since they were fetched
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc <= `ALE_PC_RST;
    end else if (exec_now && is_jump) begin
      pc <= jump_target(literal_i, upper_jump_latch_i);
    end else if (instr_valid_i) begin
      pc <= pc_step(pc);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // File register write port

  // Write strobe, one cycle after the slot
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      file_we_o <= 1'b0;
    end else begin
      file_we_o <= exec_now && to_file;
    end
  end

  // Address and data hold after the strobe so a slow file can still take them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      file_waddr_o <= 7'h00;
      file_wdata_o <= 8'h00;
    end else if (exec_now && to_file) begin
      file_waddr_o <= file_addr_i;
      file_wdata_o <= alu_bus.result;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core state outputs

  // Registered copy of the accumulator
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      accumulator_o <= `ALE_ACC_RST;
    end else begin
      accumulator_o <= acc;
    end
  end

  // Registered copy of the zero flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      zero_flag_o <= `ALE_ZERO_RST;
    end else begin
      zero_flag_o <= zero;
    end
  end

  // Registered copy of the program counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      program_counter_o <= `ALE_PC_RST;
    end else begin
      program_counter_o <= pc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-cycle status

  // Pulse for a slot that executed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      retire_o <= 1'b0;
    end else begin
      retire_o <= exec_now;
    end
  end

  // Pulse for a slot dropped as a NOP
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      discard_o <= 1'b0;
    end else begin
      discard_o <= instr_valid_i && discarding;
    end
  end

  // Pulse for an executed jump
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      jump_o <= 1'b0;
    end else begin
      jump_o <= exec_now && is_jump;
    end
  end

  // Pulse for a skip-on-null with a zero result
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      skip_taken_o <= 1'b0;
    end else begin
      skip_taken_o <= skip_now;
    end
  end

  // Cycle count of the instruction just taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cycles_o <= 2'h0;
    end else if (exec_now) begin
      cycles_o <= next_discard ? `ALE_CYC_TWO : `ALE_CYC_PLAIN;
    end
  end

  // Unsupported codes execute as a NOP and are flagged
  // Flagged so the core can trap, while the slot itself changes nothing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      illegal_op_o <= 1'b0;
    end else begin
      illegal_op_o <= exec_now && !is_known(op_i);
    end
  end

endmodule

// ==== sim/ale_exec_asserts.sv ====
`timescale 1ns/1ps
module ale_exec_asserts (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Slot inputs
  input wire logic instr_valid_i,
  input wire logic [2:0] op_i,
  input wire logic dest_i,
  input wire logic [10:0] literal_i,
  input wire logic [7:0] file_rdata_i,
  input wire logic [7:0] upper_jump_latch_i,
  // Results
  input wire logic file_we_o,
  input wire logic [7:0] file_wdata_o,
  input wire logic [7:0] accumulator_o,
  input wire logic zero_flag_o,
  input wire logic [12:0] program_counter_o,
  input wire logic retire_o,
  input wire logic discard_o,
  input wire logic jump_o,
  input wire logic skip_taken_o,
  input wire logic [1:0] cycles_o
);
  logic [2:0] p_op;
  logic p_dest;
  logic [7:0] p_fd;
  logic [12:0] p_pc;
  ////////////////////
  // Slot fields, lined up with the pulses
  always_ff @(posedge clk_i) begin
    p_op <= op_i;
    p_dest <= dest_i;
    p_fd <= file_rdata_i;
    p_pc <= {upper_jump_latch_i[4:3], literal_i};
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Zero skip with a slot behind it
  sequence s_skip_slot;
    skip_taken_o && instr_valid_i;
  endsequence
  // Jump with a slot behind it
  sequence s_jump_slot;
    jump_o && instr_valid_i;
  endsequence
  // Executed op that writes accumulator and flag
  sequence s_zero_op;
    retire_o && (p_op == 3'h4 || (!p_dest && (p_op == 3'h3 || p_op == 3'h5)));
  endsequence
  chk_jump_cycles: assert property (jump_o |-> cycles_o == 2'h2)
    else $error("jump cycles");
  chk_jump_target: assert property (jump_o |-> ##1
    program_counter_o == $past(p_pc)) else $error("jump target");
  chk_flags_kept: assert property ((jump_o || skip_taken_o) |=>
    $stable(zero_flag_o)) else $error("flag moved");
  chk_skip_discard: assert property (s_skip_slot |=> discard_o && !file_we_o)
    else $error("no discard");
  chk_skip_zero: assert property (retire_o && (p_op == 3'h1 || p_op == 3'h2) |->
    skip_taken_o == (p_fd == (p_op == 3'h1 ? 8'h01 : 8'hff))) else $error("skip");
  chk_dest_write: assert property (retire_o |-> file_we_o ==
    (p_dest && p_op inside {3'h1, 3'h2, 3'h3, 3'h5})) else $error("write enable");
  chk_write_data: assert property (retire_o && file_we_o && p_op != 3'h5 |->
    file_wdata_o == (p_op == 3'h1 ? p_fd - 8'h01 : p_fd + 8'h01)) else $error("write data");
  chk_zero_result: assert property (s_zero_op |=>
    zero_flag_o == (accumulator_o == 8'h00)) else $error("zero flag");
  chk_jump_discard: assert property (s_jump_slot |=> discard_o && !retire_o)
    else $error("jump slot kept");
  chk_cycles_plain: assert property (retire_o && !skip_taken_o && !jump_o |->
    cycles_o == 2'h1) else $error("plain cycles");
endmodule
bind ale_exec ale_exec_asserts u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i), .op_i(op_i),
  .dest_i(dest_i), .literal_i(literal_i), .file_rdata_i(file_rdata_i),
  .upper_jump_latch_i(upper_jump_latch_i), .file_we_o(file_we_o),
  .file_wdata_o(file_wdata_o), .accumulator_o(accumulator_o), .zero_flag_o(zero_flag_o),
  .program_counter_o(program_counter_o), .retire_o(retire_o), .discard_o(discard_o),
  .jump_o(jump_o), .skip_taken_o(skip_taken_o), .cycles_o(cycles_o)
);

// ==== sim/ale_exec_tb.sv ====
`timescale 1ns/1ps
module ale_exec_tb;
  logic clk_i = 1'b0, rst_i = 1'b1, instr_valid_i = 1'b0, dest_i = 1'b0;
  logic [2:0] op_i = 3'h0;
  logic [6:0] file_addr_i = 7'h2a, file_waddr_o;
  logic [10:0] literal_i = 11'h000;
  logic [7:0] file_rdata_i = 8'h00, upper_jump_latch_i = 8'h00;
  logic [7:0] file_wdata_o, accumulator_o;
  logic file_we_o, zero_flag_o, retire_o, discard_o, jump_o, skip_taken_o, illegal_op_o;
  logic [12:0] program_counter_o;
  logic [1:0] cycles_o;
  int n_mismatch = 0, tests_run = 0;
  // Instruction clock, 25 ns period
  always #12.5 clk_i = ~clk_i;
  ale_exec DUT (
    .clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i), .op_i(op_i),
    .file_addr_i(file_addr_i), .dest_i(dest_i), .literal_i(literal_i),
    .file_rdata_i(file_rdata_i), .upper_jump_latch_i(upper_jump_latch_i),
    .file_we_o(file_we_o), .file_waddr_o(file_waddr_o), .file_wdata_o(file_wdata_o),
    .accumulator_o(accumulator_o), .zero_flag_o(zero_flag_o),
    .program_counter_o(program_counter_o), .retire_o(retire_o), .discard_o(discard_o),
    .jump_o(jump_o), .skip_taken_o(skip_taken_o), .cycles_o(cycles_o),
    .illegal_op_o(illegal_op_o)
  );
  ////////////////////
  // Compare and count
  task automatic ck(input string nm, input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Counts and verdict
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // One slot; returns in the cycle of its pulses
  task automatic issue(input logic [2:0] op, input logic d, input logic [10:0] k,
    input logic [7:0] f);
    instr_valid_i = 1'b1;
    op_i = op;
    dest_i = d;
    literal_i = k;
    file_rdata_i = f;
    @(negedge clk_i);
  endtask
  // Empty cycle
  task automatic idle();
    instr_valid_i = 1'b0;
    @(negedge clk_i);
  endtask
  // Decrement skip on zero, then wrap with no skip
  task automatic t_dec();
    issue(3'h1, 1'b0, 11'h010, 8'h01);
    ck("skip", skip_taken_o, 1'b1);
    issue(3'h4, 1'b0, 11'h0ff, 8'h00);
    issue(3'h1, 1'b1, 11'h023, 8'h00);
    ck("acc", accumulator_o, 8'h00);
    ck("zero", zero_flag_o, 1'b0);
    ck("wdata", file_wdata_o, 8'hff);
    issue(3'h4, 1'b0, 11'h001, 8'h00);
    ck("disc", discard_o, 1'b0);
    idle();
    ck("acc", accumulator_o, 8'h01);
  endtask
  // Increment skip keeps the flag, plain increment sets it
  task automatic t_inc();
    issue(3'h2, 1'b1, 11'h044, 8'hff);
    ck("wdata", file_wdata_o, 8'h00);
    issue(3'h3, 1'b0, 11'h044, 8'hff);
    issue(3'h3, 1'b0, 11'h011, 8'hff);
    ck("zero", zero_flag_o, 1'b0);
    idle();
    ck("zero", zero_flag_o, 1'b1);
  endtask
  // Jump with latch bits; flag and next slot untouched
  task automatic t_jump();
    upper_jump_latch_i = 8'h18;
    issue(3'h6, 1'b0, 11'h123, 8'h00);
    ck("jump", jump_o, 1'b1);
    issue(3'h4, 1'b0, 11'h0ff, 8'h00);
    ck("pc", program_counter_o, 13'h1923);
    idle();
    ck("acc", accumulator_o, 8'h00);
    ck("zero", zero_flag_o, 1'b1);
  endtask
  // OR into file, then into accumulator
  task automatic t_or();
    issue(3'h4, 1'b0, 11'h0c0, 8'h00);
    issue(3'h5, 1'b1, 11'h055, 8'h03);
    ck("wdata", file_wdata_o, 8'hc3);
    issue(3'h5, 1'b0, 11'h000, 8'h0c);
    idle();
    ck("acc", accumulator_o, 8'hcc);
  endtask
  // Unknown code and NOP change nothing; nonzero increment skip runs on
  task automatic t_nop();
    issue(3'h7, 1'b0, 11'h000, 8'h00);
    ck("illegal", illegal_op_o, 1'b1);
    ck("cycles", cycles_o, 2'h1);
    issue(3'h0, 1'b0, 11'h000, 8'h00);
    ck("illegal", illegal_op_o, 1'b0);
    ck("retire", retire_o, 1'b1);
    issue(3'h2, 1'b0, 11'h000, 8'h7f);
    ck("skip", skip_taken_o, 1'b0);
    ck("cycles", cycles_o, 2'h1);
    ck("we", file_we_o, 1'b0);
  endtask
  // Zero decrement to file, idle, then the waiting slot is dropped
  task automatic t_wait();
    file_addr_i = 7'h33;
    issue(3'h1, 1'b1, 11'h000, 8'h01);
    ck("we", file_we_o, 1'b1);
    ck("waddr", file_waddr_o, 7'h33);
    ck("cycles", cycles_o, 2'h2);
    ck("acc", accumulator_o, 8'h80);
    idle();
    issue(3'h4, 1'b0, 11'h0ff, 8'h00);
    ck("disc", discard_o, 1'b1);
    ck("retire", retire_o, 1'b0);
    idle();
    ck("acc", accumulator_o, 8'h80);
    ck("zero", zero_flag_o, 1'b0);
  endtask
  // Reset for 8 cycles, then scenarios
  initial begin
    repeat (8) @(negedge clk_i);
    rst_i = 1'b0;
    t_dec();
    t_inc();
    t_jump();
    t_or();
    t_nop();
    t_wait();
    idle();
    test_done();
  end
endmodule
